// File: design/rdt_top.sv
// Reload down timer channel with Avalon-MM register slave
//
// Overview of operation
// - Once running, count down from the reload value and pulse on underflow.
// - Underflows repeat every reload value plus one divided clock ticks.
// - Repeat mode reloads on each underflow and counts until run is cleared.
// - One-shot mode reloads on first underflow, then halts and clears run.
// - Underflow drives peripheral clock (repeat only) and interrupt logic.
// - Run bit 8 starts on 1, stops on 0, reads running state.
// - Preset bit 1 copies reload into counter, reads 1 while pending.
// - Clock gate bit 0 enables the counter clock; resets to 0.
// - Reload register resets to 0xffff; copied into the count on preset or underflow.
// - Read-only count register shows live count, resets to 0xffff.
// - Underflow flag set by underflow, cleared by writing 1, resets 0.
// - Interrupt request only while flag and its enable are both set.
// - Debug keep-running bit 8 keeps counting during debug halt.
// - Four-bit divide code picks power-of-two ratio 1/1 to 1/32768.
// - Two-bit source picks one of three oscillators or external input.
// - Sources not implemented cannot clock the counter.
// - Interrupt enable bit 0 permits underflow requests; resets to 0.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module rdt_top
   import rdt_pkg::*;
#(
   // Bit n set means source code n exists on this channel
   parameter logic [3:0] SRC_PRESENT = 4'hF
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [rdt_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [rdt_pkg::DATA_W-1:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [rdt_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Clock sources, asynchronous to clk_in
   input wire logic internal_rc_oscillator_in,
   input wire logic low_speed_oscillator_in,
   input wire logic high_speed_oscillator_in,
   input wire logic external_clock_input_in,
   // CPU debug halt, same clock domain
   input wire logic debug_halt_in,
   // Events
   output logic underflow_pulse_out,
   output logic peripheral_clock_out,
   output logic irq_out
);
   import rdt_pkg::*;

   if (SRC_PRESENT == 4'h0) begin : g_chk
      $error("rdt_top: at least one clock source must be present");
   end
   // Byte-enable lanes and the upper-zero read word assume a 32-bit bus
   if (DATA_W != 32) begin : g_chk_data
      $error("rdt_top: data bus must be 32 bits wide");
   end
   // The lane merge serves exactly one 16-bit register per word
   if (CNT_W != 16) begin : g_chk_width
      $error("rdt_top: register width must be 16");
   end
   // The prescaler must hold the mask of the slowest divide code
   if (DIV_W < 15) begin : g_chk_div
      $error("rdt_top: prescaler narrower than divide code 0xF needs");
   end
   // Every register offset has to fit the address port
   if (ADDR_W < 5) begin : g_chk_addr
      $error("rdt_top: address port too narrow for the register map");
   end
   // Field positions must fall inside the 16-bit register word
   if (POS_RUN >= CNT_W || POS_DEBUG_KEEP_RUNNING >= CNT_W
         || POS_DIVIDE_LSB + 4 > CNT_W) begin : g_chk_pos
      $error("rdt_top: a field position lies outside the register word");
   end

   typedef struct packed {
      // Bus answer
      logic ack;
      logic [DATA_W-1:0] rdata;
      // Source sampling and prescaler
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] sync3;
      logic [3:0] level;
      logic src_edge;
      logic [DIV_W-1:0] prescale;
      // Software-visible fields
      logic debug_keep_running;
      logic [3:0] clock_divide_select;
      logic [1:0] clock_source_select;
      logic oneshot_select;
      logic run_control_bit;
      logic preset_pending;
      logic count_clock_gate;
      logic [CNT_W-1:0] reload_field;
      logic [CNT_W-1:0] count_field;
      logic underflow_flag;
      logic underflow_irq_enable;
      // Event outputs
      logic uf_pulse;
      logic pclk;
      logic irq;
   } rdt_state_t;

   rdt_state_t state_reg;
   rdt_state_t state_next;

   // Low-order mask that a divide code waits on
   // Code 0 gives an empty mask, so every source edge is a tick
   function automatic logic [DIV_W-1:0] rdt_div_mask(input logic [3:0] code);
      logic [DIV_W:0] one_hot;
      one_hot = '0;
      one_hot[code] = 1'b1;
      return DIV_W'(one_hot - 1'b1);
   endfunction : rdt_div_mask

   // Byte-lane merge of a 16-bit register
   function automatic logic [CNT_W-1:0] rdt_merge(input logic [CNT_W-1:0] old,
         input logic [DATA_W-1:0] wd, input logic [3:0] be);
      logic [CNT_W-1:0] res;
      res = old;
      if (be[0]) begin
         res[7:0] = wd[7:0];
      end
      if (be[1]) begin
         res[15:8] = wd[15:8];
      end
      return res;
   endfunction : rdt_merge

   // Whether a source may run at a given divide code
   function automatic logic rdt_src_ok(input logic [1:0] src, input logic [3:0] dv,
         input logic [3:0] present);
      logic ok;
      ok = 1'b0;
      case (src)
         // The fast sources take every ratio
         SRC_RC_OSC: begin
            ok = dv <= MAXDIV_RC_OSC;
         end
         // The slow oscillator stops at a lower ratio
         SRC_LOW_OSC: begin
            ok = dv <= MAXDIV_LOW_OSC;
         end
         SRC_HIGH_OSC: begin
            ok = dv <= MAXDIV_HIGH_OSC;
         end
         // The external input is counted undivided only
         default: begin
            ok = dv <= MAXDIV_EXTERNAL;
         end
      endcase
      return ok & present[src];
   endfunction : rdt_src_ok

   // Read word of one register; reserved bits and unmapped offsets read 0
   // A read has no side effect, so polling the flag never clears it
   function automatic logic [DATA_W-1:0] rdt_read_word(input rdt_state_t s,
         input logic [ADDR_W-1:0] addr);
      logic [DATA_W-1:0] word;
      word = '0;
      case (addr)
         OFS_CLOCK_SELECT: begin
            word[POS_DEBUG_KEEP_RUNNING] = s.debug_keep_running;
            word[POS_DIVIDE_LSB +: 4] = s.clock_divide_select;
            word[POS_SOURCE_LSB +: 2] = s.clock_source_select;
         end
         OFS_MODE_SELECT: begin
            word[POS_ONESHOT] = s.oneshot_select;
         end
         OFS_RUN_CONTROL: begin
            word[POS_RUN] = s.run_control_bit;
            word[POS_PRESET] = s.preset_pending;
            word[POS_GATE] = s.count_clock_gate;
         end
         OFS_RELOAD_VALUE: begin
            word[CNT_W-1:0] = s.reload_field;
         end
         OFS_COUNT_VALUE: begin
            word[CNT_W-1:0] = s.count_field;
         end
         OFS_UNDERFLOW_STATUS: begin
            word[POS_UNDERFLOW_FLAG] = s.underflow_flag;
         end
         OFS_UNDERFLOW_IRQ_MASK: begin
            word[POS_UNDERFLOW_IE] = s.underflow_irq_enable;
         end
         default: begin
         end
      endcase
      return word;
   endfunction : rdt_read_word

   logic wr_hit;
   logic rd_hit;
   logic [3:0] src_raw;
   logic [3:0] level_new;
   logic [CNT_W-1:0] wd16;
   logic count_enable;
   logic div_tick;
   logic [DIV_W-1:0] div_mask;

   // A source that is not fitted is held low, so its sampler never moves
   assign src_raw = {external_clock_input_in, high_speed_oscillator_in,
                     low_speed_oscillator_in, internal_rc_oscillator_in} & SRC_PRESENT;

   always_comb begin
      state_next = state_reg;
      // Writes take effect at the edge where waitrequest is seen low
      wr_hit = avs_write_in & state_reg.ack;
      rd_hit = avs_read_in & ~state_reg.ack;
      wd16 = avs_writedata_in[CNT_W-1:0];
      state_next.ack = (avs_read_in | avs_write_in) & ~state_reg.ack;
      // The answer comes one cycle after the request; a request still held at the
      // answer edge is not taken twice, as ack is cleared there

      // Three-stage sampling; a level moves only once stages two and three agree
      // Limitation: a level must stand two bus clocks to be seen, so a source
      // faster than a quarter of the bus clock loses edges
      state_next.sync1 = src_raw;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      level_new = state_reg.level;
      for (int i = 0; i < 4; i++) begin
         if (state_reg.sync2[i] == state_reg.sync3[i]) begin
            level_new[i] = state_reg.sync3[i];
         end
      end
      state_next.level = level_new;
      state_next.src_edge = level_new[state_reg.clock_source_select]
            & ~state_reg.level[state_reg.clock_source_select]
            & rdt_src_ok(state_reg.clock_source_select, state_reg.clock_divide_select,
                         SRC_PRESENT);

      // debug halt suspends unless kept running
      count_enable = state_reg.count_clock_gate
            & (~debug_halt_in | state_reg.debug_keep_running);
      // power-of-two division of source edges
      // The prescaler is not restarted on a divide change, so the first tick after
      // a change may come early; change the divider while stopped
      div_mask = rdt_div_mask(state_reg.clock_divide_select);
      div_tick = 1'b0;
      if (count_enable & state_reg.src_edge) begin
         state_next.prescale = DIV_W'(state_reg.prescale + 1'b1);
         div_tick = (state_reg.prescale & div_mask) == div_mask;
      end

      // Counter and event outputs
      state_next.uf_pulse = 1'b0;
      state_next.pclk = 1'b0;
      // pending preset is served once counting is enabled: gate open, and no debug halt unless kept running
      // A tick that falls in the preset cycle is dropped, as the count restarts
      if (state_reg.preset_pending & count_enable) begin
         state_next.count_field = state_reg.reload_field;
         state_next.preset_pending = 1'b0;
      end else if (state_reg.run_control_bit & div_tick) begin
         // decrement per tick, reload when passing zero
         // period is reload plus one ticks
         if (state_reg.count_field == '0) begin
            state_next.count_field = state_reg.reload_field;
            state_next.uf_pulse = 1'b1;
            // clock out only in repeat mode
            state_next.pclk = ~state_reg.oneshot_select;
            if (state_reg.oneshot_select) begin
               state_next.run_control_bit = 1'b0;
            end
            state_next.underflow_flag = 1'b1;
         end else begin
            state_next.count_field = CNT_W'(state_reg.count_field - 1'b1);
         end
      end

      // Register writes
      if (wr_hit) begin
         case (avs_address_in)
            OFS_CLOCK_SELECT: begin
               if (avs_byteenable_in[1]) begin
                  state_next.debug_keep_running = wd16[POS_DEBUG_KEEP_RUNNING];
               end
               if (avs_byteenable_in[0]) begin
                  state_next.clock_divide_select = wd16[POS_DIVIDE_LSB +: 4];
                  state_next.clock_source_select = wd16[POS_SOURCE_LSB +: 2];
               end
            end
            OFS_MODE_SELECT: begin
               if (avs_byteenable_in[0]) begin
                  state_next.oneshot_select = wd16[POS_ONESHOT];
               end
            end
            OFS_RUN_CONTROL: begin
               // software start or stop wins over one-shot halt
               if (avs_byteenable_in[1]) begin
                  state_next.run_control_bit = wd16[POS_RUN];
               end
               if (avs_byteenable_in[0]) begin
                  state_next.count_clock_gate = wd16[POS_GATE];
                  // writing 0 leaves a pending preset alone
                  if (wd16[POS_PRESET]) begin
                     state_next.preset_pending = 1'b1;
                  end
               end
            end
            OFS_RELOAD_VALUE: begin
               // Taken even while running; a stopped timer is the safe time to write
               state_next.reload_field = rdt_merge(state_reg.reload_field,
                                                   avs_writedata_in, avs_byteenable_in);
            end
            OFS_COUNT_VALUE: begin
               // the count is read only; a write is answered and dropped
            end
            OFS_UNDERFLOW_STATUS: begin
               // write 1 clears, a same-cycle underflow wins
               if (avs_byteenable_in[0] & wd16[POS_UNDERFLOW_FLAG]
                     & ~state_next.uf_pulse) begin
                  state_next.underflow_flag = 1'b0;
               end
            end
            OFS_UNDERFLOW_IRQ_MASK: begin
               if (avs_byteenable_in[0]) begin
                  state_next.underflow_irq_enable = wd16[POS_UNDERFLOW_IE];
               end
            end
            default: begin
            end
         endcase
      end

      // request is flag and enable
      // Taken from the next flag and enable, so irq moves in step with the flag
      state_next.irq = state_next.underflow_flag & state_next.underflow_irq_enable;

      // Read data holds until the next read is taken
      if (rd_hit) begin
         state_next.rdata = rdt_read_word(state_reg, avs_address_in);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         // Clear all, then load the divide, source, reload and count reset values
         state_reg <= '0;
         state_reg.clock_divide_select <= RST_DIVIDE;
         state_reg.clock_source_select <= RST_SOURCE;
         state_reg.reload_field <= RST_RELOAD;
         state_reg.count_field <= RST_COUNT;
      end else begin
         state_reg <= state_next;
      end
   end

   // Every output is a register field; only waitrequest has logic after the flop, an inverter on ack
   assign avs_readdata_out = state_reg.rdata;
   assign avs_waitrequest_out = ~state_reg.ack;
   assign underflow_pulse_out = state_reg.uf_pulse;
   assign peripheral_clock_out = state_reg.pclk;
   assign irq_out = state_reg.irq;
endmodule : rdt_top

// File: design/rdt_pkg.sv
// Register map, field layout and reset values of the reload down timer
package rdt_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int DIV_W = 15;
   // Byte offsets of the word registers
   localparam logic [ADDR_W-1:0] OFS_CLOCK_SELECT = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_MODE_SELECT = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_RUN_CONTROL = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_COUNT_VALUE = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_UNDERFLOW_STATUS = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_UNDERFLOW_IRQ_MASK = 5'h18;
   // Field positions
   localparam int POS_DEBUG_KEEP_RUNNING = 8;
   localparam int POS_DIVIDE_LSB = 4;
   localparam int POS_SOURCE_LSB = 0;
   localparam int POS_ONESHOT = 0;
   localparam int POS_RUN = 8;
   localparam int POS_PRESET = 1;
   localparam int POS_GATE = 0;
   localparam int POS_UNDERFLOW_FLAG = 0;
   localparam int POS_UNDERFLOW_IE = 0;
   // Reset values
   localparam logic [CNT_W-1:0] RST_RELOAD = 16'hFFFF;
   localparam logic [CNT_W-1:0] RST_COUNT = 16'hFFFF;
   localparam logic [3:0] RST_DIVIDE = 4'h0;
   localparam logic [1:0] RST_SOURCE = 2'h0;
   // Clock source codes
   localparam logic [1:0] SRC_RC_OSC = 2'h0;
   localparam logic [1:0] SRC_LOW_OSC = 2'h1;
   localparam logic [1:0] SRC_HIGH_OSC = 2'h2;
   localparam logic [1:0] SRC_EXTERNAL = 2'h3;
   // Highest divide code each source accepts
   localparam logic [3:0] MAXDIV_RC_OSC = 4'hF;
   localparam logic [3:0] MAXDIV_LOW_OSC = 4'h8;
   localparam logic [3:0] MAXDIV_HIGH_OSC = 4'hF;
   localparam logic [3:0] MAXDIV_EXTERNAL = 4'h0;
endpackage : rdt_pkg

// File: sim/rdt_asserts.sv
// Port-level checks of the reload down timer
`timescale 1ns/1ps
module rdt_asserts
   import rdt_pkg::*;
(
   // Watched ports
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [rdt_pkg::DATA_W-1:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic underflow_pulse_out,
   input wire logic peripheral_clock_out,
   input wire logic irq_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic ack1_reg;
   logic ack2_reg;
   // Remembers recent write acknowledges, the only legal cause of an irq change besides underflow
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack1_reg <= 1'b0;
         ack2_reg <= 1'b0;
      end else begin
         ack1_reg <= avs_write_in && !avs_waitrequest_out;
         ack2_reg <= ack1_reg;
      end
   end
   a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("request not answered next cycle");
   a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low too long");
   a_idle_quiet: assert property (!avs_read_in && !avs_write_in && avs_waitrequest_out
      |=> avs_waitrequest_out) else $error("answer without request");
   a_upper_zero: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   a_pulse_single: assert property (underflow_pulse_out |=> !underflow_pulse_out)
      else $error("underflow pulse longer than one cycle");
   a_periph_with_pulse: assert property (peripheral_clock_out |-> underflow_pulse_out)
      else $error("peripheral clock without underflow");
   a_irq_rise_cause: assert property ($rose(irq_out) |-> underflow_pulse_out || ack1_reg ||
      ack2_reg) else $error("irq rose without cause");
   a_irq_fall_cause: assert property ($fell(irq_out) |-> ack1_reg || ack2_reg)
      else $error("irq fell without write");
endmodule : rdt_asserts

// File: sim/test_rdt_top.sv
// Self-checking bench of the reload down timer
`timescale 1ns/1ps
module test_rdt_top;
   import rdt_pkg::*;
   typedef struct packed {logic [4:0] a; logic w; logic [15:0] d; logic [15:0] e;} rdt_row_t;
   localparam rdt_row_t ROWS [15] = '{
      '{OFS_CLOCK_SELECT, 1'b0, 16'h0000, 16'h0000}, '{OFS_MODE_SELECT, 1'b0, 16'h0000, 16'h0000},
      '{OFS_RUN_CONTROL, 1'b0, 16'h0000, 16'h0000}, '{OFS_RELOAD_VALUE, 1'b0, 16'h0000, 16'hFFFF},
      '{OFS_COUNT_VALUE, 1'b0, 16'h0000, 16'hFFFF}, '{OFS_UNDERFLOW_STATUS, 1'b0, 16'h0000, 16'h0000},
      '{OFS_UNDERFLOW_IRQ_MASK, 1'b0, 16'h0000, 16'h0000}, '{5'h1C, 1'b0, 16'h0000, 16'h0000},
      '{5'h1C, 1'b1, 16'hFFFF, 16'h0000}, '{OFS_COUNT_VALUE, 1'b1, 16'h1234, 16'hFFFF},
      '{OFS_UNDERFLOW_STATUS, 1'b1, 16'hFFFF, 16'h0000}, '{OFS_CLOCK_SELECT, 1'b1, 16'hFFFF, 16'h01F3},
      '{OFS_MODE_SELECT, 1'b1, 16'hFFFF, 16'h0001}, '{OFS_UNDERFLOW_IRQ_MASK, 1'b1, 16'hFFFF, 16'h0001},
      '{OFS_RELOAD_VALUE, 1'b1, 16'h0003, 16'h0003}};
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [ADDR_W-1:0] avs_address_in = '0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [DATA_W-1:0] avs_writedata_in = '0;
   logic [DATA_W-1:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [4:0] src_cnt = 5'h00;
   logic [3:0] be = 4'hF;
   logic debug_halt_in = 1'b0;
   logic underflow_pulse_out;
   logic peripheral_clock_out;
   logic irq_out;
   logic [31:0] n;
   logic pc;
   int err_count = 0;
   int compares = 0;
   always #4 clk_in = ~clk_in;
   // Source k runs at 1/2^(k+2) of the bus clock: the sampler needs each level for two cycles
   always @(posedge clk_in) src_cnt <= src_cnt + 5'h01;
   rdt_top dut (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(be), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .internal_rc_oscillator_in(src_cnt[1]),
      .low_speed_oscillator_in(src_cnt[2]), .high_speed_oscillator_in(src_cnt[3]),
      .external_clock_input_in(src_cnt[4]), .debug_halt_in(debug_halt_in),
      .underflow_pulse_out(underflow_pulse_out), .peripheral_clock_out(peripheral_clock_out),
      .irq_out(irq_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d,
         output logic [15:0] q);
      int k;
      k = 0;
      avs_address_in <= a;
      avs_writedata_in <= {16'h0000, d};
      avs_read_in <= !w;
      avs_write_in <= w;
      do begin
         @(posedge clk_in);
         k++;
      end while (avs_waitrequest_out !== 1'b0 && k < 50);
      q = avs_readdata_out[15:0];
      if (k >= 50) chk(32'h0, 32'h1);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clk_in);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(a, 1'b0, 16'h0000, q);
      chk({16'h0000, q}, {16'h0000, e});
   endtask : rd_chk
   // Cycles to the next underflow pulse; 3000 means none came
   task automatic next_pulse(output logic [31:0] c, output logic p);
      c = 0;
      do begin
         @(posedge clk_in);
         c++;
      end while (underflow_pulse_out !== 1'b1 && c < 3000);
      p = peripheral_clock_out;
   endtask : next_pulse
   task automatic results;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      #320_000;
      chk(32'h0, 32'h1);
      results();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      foreach (ROWS[i]) begin
         if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
         rd_chk(ROWS[i].a, ROWS[i].e);
      end
      $display("register table test done");
      wr(OFS_MODE_SELECT, 16'h0000);
      wr(OFS_RUN_CONTROL, 16'h0103);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_CLOCK_SELECT, 16'(k));
         next_pulse(n, pc);
         next_pulse(n, pc);
         chk(n, 32'd16 << k);
         chk({31'h0, pc}, 32'h1);
      end
      wr(OFS_CLOCK_SELECT, 16'h0020);
      next_pulse(n, pc);
      next_pulse(n, pc);
      chk(n, 32'd64);
      wr(OFS_CLOCK_SELECT, 16'h0091);
      next_pulse(n, pc);
      chk(n, 32'd3000);
      wr(OFS_CLOCK_SELECT, 16'h0000);
      debug_halt_in <= 1'b1;
      next_pulse(n, pc);
      chk(n, 32'd3000);
      wr(OFS_CLOCK_SELECT, 16'h0100);
      next_pulse(n, pc);
      next_pulse(n, pc);
      chk(n, 32'd16);
      debug_halt_in <= 1'b0;
      rd_chk(OFS_RUN_CONTROL, 16'h0101);
      wr(OFS_RUN_CONTROL, 16'h0001);
      rd_chk(OFS_RUN_CONTROL, 16'h0001);
      next_pulse(n, pc);
      chk(n, 32'd3000);
      $display("repeat mode test done");
      wr(OFS_UNDERFLOW_STATUS, 16'h0000);
      rd_chk(OFS_UNDERFLOW_STATUS, 16'h0001);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h1);
      wr(OFS_UNDERFLOW_IRQ_MASK, 16'h0000);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h0);
      wr(OFS_UNDERFLOW_IRQ_MASK, 16'h0001);
      wr(OFS_UNDERFLOW_STATUS, 16'h0001);
      repeat (2) @(posedge clk_in);
      chk({31'h0, irq_out}, 32'h0);
      rd_chk(OFS_UNDERFLOW_STATUS, 16'h0000);
      $display("interrupt test done");
      wr(OFS_RUN_CONTROL, 16'h0000);
      wr(OFS_RELOAD_VALUE, 16'h0005);
      wr(OFS_RUN_CONTROL, 16'h0002);
      rd_chk(OFS_RUN_CONTROL, 16'h0002);
      wr(OFS_RUN_CONTROL, 16'h0003);
      rd_chk(OFS_RUN_CONTROL, 16'h0001);
      rd_chk(OFS_COUNT_VALUE, 16'h0005);
      be <= 4'h1;
      wr(OFS_RELOAD_VALUE, 16'hAB12);
      be <= 4'hF;
      rd_chk(OFS_RELOAD_VALUE, 16'h0012);
      $display("preset test done");
      wr(OFS_MODE_SELECT, 16'h0001);
      wr(OFS_RELOAD_VALUE, 16'h0002);
      wr(OFS_RUN_CONTROL, 16'h0103);
      next_pulse(n, pc);
      chk({31'h0, pc}, 32'h0);
      rd_chk(OFS_RUN_CONTROL, 16'h0001);
      rd_chk(OFS_COUNT_VALUE, 16'h0002);
      next_pulse(n, pc);
      chk(n, 32'd3000);
      $display("one-shot test done");
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd_chk(OFS_COUNT_VALUE, 16'hFFFF);
      rd_chk(OFS_MODE_SELECT, 16'h0000);
      $display("reset test done");
      results();
   end
endmodule : test_rdt_top
bind rdt_top rdt_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .underflow_pulse_out(underflow_pulse_out),
   .peripheral_clock_out(peripheral_clock_out), .irq_out(irq_out));
